// ==== sim/fmon_fault_monitor_assertions.sv ====
module fmon_fault_monitor_chk
    import fmon_pkg::*;
#(
    parameter int SC_WIN_CYC  = FMON_SC_WIN_CYC,
    parameter int TO_STEP_CYC = FMON_TO_STEP_CYC
) (
    input wire logic       sys_clk,
    input wire logic       resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       temp_hot_cmp,
    input wire logic       vin_uv_cmp,
    input wire logic       vin_uv_recovered,
    input wire logic       cap_open_cmp,
    input wire logic       ind_ilim_cmp,
    input wire logic       charge_phase,
    input wire logic       force_standby,
    input wire logic       charge_end,
    input wire logic [1:0] ilim_sel,
    input wire logic [2:0] lv_threshold
);
    // ********
    // checks
    // ********
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    ilim_follow_a: assert property (
        reg_wr && reg_addr == FMON_OFS_TXMASK
        |=> ilim_sel == $past(reg_wdata[1:0]))
        else $error("limit code did not follow write");
    ilim_readback_a: assert property (
        reg_rd && reg_addr == FMON_OFS_TXMASK |=> reg_rdata[1:0] == ilim_sel)
        else $error("limit code readback wrong");
    lvl_follow_a: assert property (
        reg_wr && reg_addr == FMON_OFS_LVCTRL
        |=> lv_threshold == $past(reg_wdata[2:0]))
        else $error("threshold did not follow write");
    lvl_readback_a: assert property (
        reg_rd && reg_addr == FMON_OFS_LVCTRL
        |=> reg_rdata[2:0] == lv_threshold)
        else $error("threshold readback wrong");
    charge_cause_a: assert property (
        charge_end |-> $past(charge_phase))
        else $error("charge end outside charge phase");
    charge_hit_a: assert property (
        (ind_ilim_cmp && charge_phase)[*4] |=> charge_end)
        else $error("limit hit did not end charge");
    uv_standby_a: assert property (
        vin_uv_cmp[*4] |=> force_standby)
        else $error("no standby on under-voltage");
    hot_standby_a: assert property (
        temp_hot_cmp[*4] |=> force_standby)
        else $error("no standby on over-temperature");
    uv_hold_a: assert property (
        vin_uv_cmp[*4] ##1 (!vin_uv_recovered)[*4] |-> force_standby)
        else $error("lockout left before recovery");
    cap_hold_a: assert property (
        cap_open_cmp[*4] ##1 (!reg_wr)[*8] |-> force_standby)
        else $error("capacitor lock left without reset bit");

    // main scenarios reached
    cover property (reg_rd && reg_addr == FMON_OFS_FAULT ##1 reg_rdata != 8'h00);
    cover property ($fell(force_standby));
    cover property (charge_end);
endmodule // fmon_fault_monitor_chk

bind fmon_fault_monitor fmon_fault_monitor_chk #(
    .SC_WIN_CYC(SC_WIN_CYC), .TO_STEP_CYC(TO_STEP_CYC)
) u_chk (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .temp_hot_cmp(temp_hot_cmp),
    .vin_uv_cmp(vin_uv_cmp), .vin_uv_recovered(vin_uv_recovered),
    .cap_open_cmp(cap_open_cmp), .ind_ilim_cmp(ind_ilim_cmp),
    .charge_phase(charge_phase), .force_standby(force_standby),
    .charge_end(charge_end), .ilim_sel(ilim_sel),
    .lv_threshold(lv_threshold)
);

// ==== sim/fmon_host.sv ====
module fmon_host (
    input  wire logic       sys_clk,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // host side of the register port
    // ********
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // strobe held for exactly one taking edge; idle bus shows inverted
    // values so nothing can lean on a stale address
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge sys_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // data is registered at the taking edge, so it is read just after it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge sys_clk);
        #1;
        d        = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~a;
    endtask
endmodule // fmon_host

// ==== sim/testbench.sv ====
module testbench
    import fmon_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SC_W = 20;
    localparam int TO_S = 10;
    logic       sys_clk, resetn, reg_wr, reg_rd, force_standby, charge_end;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, to_code, v;
    logic       vout_above_cmp, vled_above_cmp, vout_in_reg, temp_hot_cmp;
    logic       temp_cool_cmp, vin_uv_cmp, vin_uv_recovered, cap_open_cmp;
    logic       vin_below_lv_cmp, tx_mask_pin, strobe_pin, ind_ilim_cmp;
    logic       boost_active, flash_active, strobe_level_mode, pwm_mode_en;
    logic       charge_phase;
    logic [1:0] ilim_sel;
    logic [2:0] lv_threshold;
    int         miscompares, tests_run, cycles;

    fmon_fault_monitor #(.SC_WIN_CYC(SC_W), .TO_STEP_CYC(TO_S)) DUT (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .vout_above_cmp(vout_above_cmp),
        .vled_above_cmp(vled_above_cmp), .vout_in_reg(vout_in_reg),
        .temp_hot_cmp(temp_hot_cmp), .temp_cool_cmp(temp_cool_cmp),
        .vin_uv_cmp(vin_uv_cmp), .vin_uv_recovered(vin_uv_recovered),
        .cap_open_cmp(cap_open_cmp), .vin_below_lv_cmp(vin_below_lv_cmp),
        .tx_mask_pin(tx_mask_pin), .strobe_pin(strobe_pin),
        .ind_ilim_cmp(ind_ilim_cmp), .boost_active(boost_active),
        .flash_active(flash_active), .strobe_level_mode(strobe_level_mode),
        .pwm_mode_en(pwm_mode_en), .charge_phase(charge_phase),
        .flash_timeout_code(to_code), .force_standby(force_standby),
        .charge_end(charge_end), .ilim_sel(ilim_sel),
        .lv_threshold(lv_threshold)
    );

    fmon_host u_host (
        .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
    );

    // ********
    // helpers
    // ********
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // a hang costs a mismatch instead of a silent stall
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [7:0] e);
        u_host.rd(a, v);
        chk(n, e, v);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ********
    // sequence
    // ********
    initial begin
        {vout_above_cmp, vled_above_cmp, vout_in_reg, temp_hot_cmp} = 4'h0;
        {temp_cool_cmp, vin_uv_cmp, vin_uv_recovered, cap_open_cmp} = 4'h0;
        {vin_below_lv_cmp, tx_mask_pin, strobe_pin, ind_ilim_cmp} = 4'h0;
        {boost_active, flash_active, strobe_level_mode, pwm_mode_en} = 4'h0;
        charge_phase = 1'b0;
        to_code = 8'h00;
        resetn = 1'b0;
        cyc(10);
        resetn = 1'b1;
        rdchk("txmask", FMON_OFS_TXMASK, FMON_TXMASK_RST);
        rdchk("lvctrl", FMON_OFS_LVCTRL, FMON_LVCTRL_RST);
        rdchk("unmapped", 8'h55, 8'h00);
        for (int i = 0; i < 4; i++) begin
            u_host.wr(FMON_OFS_TXMASK, 8'h80 | 8'(i));
            chk("ilim", 8'(i), {6'h00, ilim_sel});
        end
        // report flags: input low is ignored while a flash runs
        u_host.wr(FMON_OFS_LVCTRL, 8'h45);
        {tx_mask_pin, vin_below_lv_cmp, flash_active} = 3'h7;
        cyc(6);
        chk("lvl", 8'h05, {5'h00, lv_threshold});
        rdchk("flags", FMON_OFS_FAULT, 8'h08);
        flash_active = 1'b0;
        cyc(6);
        rdchk("flags", FMON_OFS_FAULT, 8'h0A);
        chk("stby", 8'h00, {7'h00, force_standby});
        {tx_mask_pin, vin_below_lv_cmp} = 2'h0;
        cyc(4);
        rdchk("flags", FMON_OFS_FAULT, 8'h0A);
        rdchk("flags", FMON_OFS_FAULT, 8'h00);
        // over-temperature needs both cooling and a read
        temp_hot_cmp = 1'b1;
        cyc(4);
        temp_hot_cmp = 1'b0;
        cyc(4);
        chk("stby", 8'h01, {7'h00, force_standby});
        rdchk("flags", FMON_OFS_FAULT, 8'h20);
        rdchk("flags", FMON_OFS_FAULT, 8'h20);
        temp_cool_cmp = 1'b1;
        cyc(4);
        rdchk("flags", FMON_OFS_FAULT, 8'h20);
        rdchk("flags", FMON_OFS_FAULT, 8'h00);
        chk("stby", 8'h00, {7'h00, force_standby});
        // under-voltage lock holds until recovery
        vin_uv_cmp = 1'b1;
        cyc(4);
        vin_uv_cmp = 1'b0;
        cyc(4);
        rdchk("flags", FMON_OFS_FAULT, 8'h01);
        rdchk("flags", FMON_OFS_FAULT, 8'h00);
        cyc(2);
        chk("stby", 8'h01, {7'h00, force_standby});
        vin_uv_recovered = 1'b1;
        cyc(5);
        chk("stby", 8'h00, {7'h00, force_standby});
        // supply already back: the unread flag alone keeps the lock
        vin_uv_cmp = 1'b1;
        cyc(4);
        vin_uv_cmp = 1'b0;
        cyc(6);
        chk("stby", 8'h01, {7'h00, force_standby});
        rdchk("flags", FMON_OFS_FAULT, 8'h01);
        cyc(2);
        chk("stby", 8'h00, {7'h00, force_standby});
        // short: output never rises during boost
        boost_active = 1'b1;
        cyc(SC_W + 6);
        chk("stby", 8'h01, {7'h00, force_standby});
        // above threshold but not yet regulated: the short still holds
        {vout_above_cmp, vled_above_cmp} = 2'h3;
        cyc(5);
        rdchk("flags", FMON_OFS_FAULT, 8'h40);
        chk("stby", 8'h01, {7'h00, force_standby});
        vout_in_reg = 1'b1;
        cyc(5);
        rdchk("flags", FMON_OFS_FAULT, 8'h00);
        chk("stby", 8'h00, {7'h00, force_standby});
        boost_active = 1'b0;
        // level strobe time-out, code 1 is two steps
        {flash_active, strobe_level_mode, strobe_pin} = 3'h7;
        to_code = 8'h01;
        cyc(10);
        rdchk("flags", FMON_OFS_FAULT, 8'h00);
        cyc(14);
        {flash_active, strobe_pin} = 2'h0;
        rdchk("flags", FMON_OFS_FAULT, 8'h10);
        pwm_mode_en = 1'b1;
        {flash_active, strobe_pin} = 2'h3;
        cyc(30);
        {flash_active, strobe_pin} = 2'h0;
        rdchk("flags", FMON_OFS_FAULT, 8'h00);
        // open capacitor: lock needs reset bit one then zero
        cap_open_cmp = 1'b1;
        cyc(4);
        cap_open_cmp = 1'b0;
        cyc(2);
        rdchk("conv", FMON_OFS_CONV, 8'h10);
        rdchk("conv", FMON_OFS_CONV, 8'h00);
        chk("stby", 8'h01, {7'h00, force_standby});
        u_host.wr(FMON_OFS_LVCTRL, 8'h80);
        cyc(2);
        chk("stby", 8'h01, {7'h00, force_standby});
        u_host.wr(FMON_OFS_LVCTRL, 8'h00);
        cyc(2);
        chk("stby", 8'h00, {7'h00, force_standby});
        // current limit ends charge phase without a fault
        {charge_phase, ind_ilim_cmp} = 2'h3;
        cyc(5);
        chk("chg_end", 8'h01, {7'h00, charge_end});
        chk("stby", 8'h00, {7'h00, force_standby});
        charge_phase = 1'b0;
        cyc(2);
        chk("chg_end", 8'h00, {7'h00, charge_end});
        rdchk("flags", FMON_OFS_FAULT, 8'h00);
        give_verdict();
    end
endmodule // testbench

// ==== src/fmon_fault_monitor.sv ====
// Functional notes
// - short fault if output or LED not above 0.8V within 0.5 ms boost.
// - short condition ends only with output regulated and LED above 0.8V.
// - short fault reported in fault register bit 6.
// - over-temperature sets fault register bit 5.
// - over-temperature clears only when cooled and fault register read.
// - time-out fault when level strobe stays high past programmed time.
// - time-out recorded in bit 4, only with PWM mode disabled.
// - under-voltage forces standby and sets fault register bit 0.
// - leave lockout only after supply recovery and flag cleared.
// - open output capacitor sets bit 4 of converter monitor register.
// - after open capacitor, resume once reset bit written one then zero.
// - input low flag bit 1 set when enable bit 6 and input low.
// - threshold from three-bit field; input low sampled only outside a flash.
// - input low flag is report only, no standby, no reset.
// - transmit mask flag bit 3 set when enable bit 7 and pin high.
// - transmit mask flag is report only, no standby, no reset.
// - current limit hit ends that cycle's charge phase, cycle by cycle.
// - current limit never disables the device nor sets a fault.
// - four current limit settings in a two-bit field, default 2.6 A.
// - any fault other than input low or transmit mask latches its flag, forces standby at least until register read.
// - reading a fault register clears its latched flags, over-temperature only once cooled.
module fmon_fault_monitor
    import fmon_pkg::*;
#(
    parameter int SC_WIN_CYC  = FMON_SC_WIN_CYC,
    parameter int TO_STEP_CYC = FMON_TO_STEP_CYC
) (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // register port from the serial front end
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // comparator and pin levels, asynchronous
    input  wire logic       vout_above_cmp,
    input  wire logic       vled_above_cmp,
    input  wire logic       vout_in_reg,
    input  wire logic       temp_hot_cmp,
    input  wire logic       temp_cool_cmp,
    input  wire logic       vin_uv_cmp,
    input  wire logic       vin_uv_recovered,
    input  wire logic       cap_open_cmp,
    input  wire logic       vin_below_lv_cmp,
    input  wire logic       tx_mask_pin,
    input  wire logic       strobe_pin,
    input  wire logic       ind_ilim_cmp,
    // mode state from the sequencer, same clock
    input  wire logic       boost_active,
    input  wire logic       flash_active,
    input  wire logic       strobe_level_mode,
    input  wire logic       pwm_mode_en,
    input  wire logic       charge_phase,
    input  wire logic [7:0] flash_timeout_code,
    // to the power stage and sequencer
    output logic            force_standby,
    output logic            charge_end,
    output logic      [1:0] ilim_sel,
    output logic      [2:0] lv_threshold
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;

    assign raw_in = {ind_ilim_cmp, strobe_pin, tx_mask_pin,
                     vin_below_lv_cmp, cap_open_cmp, vin_uv_recovered,
                     vin_uv_cmp, temp_cool_cmp, temp_hot_cmp,
                     vout_in_reg, vled_above_cmp, vout_above_cmp};

    // two stages; only the second stage is read by logic
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    logic s_vout_ok;
    logic s_vled_ok;
    logic s_vout_reg;
    logic s_hot;
    logic s_cool;
    logic s_uv;
    logic s_uv_rec;
    logic s_cap_open;
    logic s_vin_low;
    logic s_txm_pin;
    logic s_strobe;
    logic s_ilim;

    assign {s_ilim, s_strobe, s_txm_pin, s_vin_low, s_cap_open, s_uv_rec,
            s_uv, s_cool, s_hot, s_vout_reg, s_vled_ok, s_vout_ok} = sync_q;

    // ************************************************************
    // timers
    // ************************************************************
    fmon_tmr_if sc_tmr ();
    fmon_tmr_if to_tmr ();

    fmon_timer u_sc_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tmr     (sc_tmr.timer)
    );

    fmon_timer u_to_timer (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .tmr     (to_tmr.timer)
    );

    // ************************************************************
    // registers and fault state
    // ************************************************************
    fmon_sc_e   sc_st_q;
    fmon_sc_e   sc_st_d;
    logic [7:0] txmask_q;
    logic [7:0] txmask_d;
    logic [7:0] lvctrl_q;
    logic [7:0] lvctrl_d;
    logic [7:0] conv_q;
    logic [7:0] conv_d;
    logic       f_sc_q,  f_sc_d;
    logic       f_ot_q,  f_ot_d;
    logic       f_to_q,  f_to_d;
    logic       f_uv_q,  f_uv_d;
    logic       f_ilv_q, f_ilv_d;
    logic       f_txm_q, f_txm_d;
    logic       f_co_q,  f_co_d;
    logic       uv_lock_q, uv_lock_d;
    logic       co_lock_q, co_lock_d;
    logic       co_arm_q,  co_arm_d;
    logic       stby_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       cend_q;
    logic       cend_d;

    logic       rd_fault;
    logic       rd_conv;
    logic       wr_lv;
    logic       sc_set;
    logic       to_set;
    logic       state_machine_reset_bit_new;

    assign rd_fault = reg_rd && (reg_addr == FMON_OFS_FAULT);
    assign rd_conv  = reg_rd && (reg_addr == FMON_OFS_CONV);
    assign wr_lv    = reg_wr && (reg_addr == FMON_OFS_LVCTRL);
    assign state_machine_reset_bit_new = reg_wdata[FMON_STATE_MACHINE_RESET_BIT_BIT];

    // window opens when boosting starts
    assign sc_tmr.run   = boost_active && (sc_st_q == FMON_SC_WATCH);
    assign sc_tmr.limit = 32'(SC_WIN_CYC);
    assign sc_set       = sc_tmr.done && !(s_vout_ok && s_vled_ok);

    // flash time-out counts only while the level strobe holds high
    assign to_tmr.run   = flash_active && strobe_level_mode && s_strobe;
    assign to_tmr.limit = (32'(flash_timeout_code) + 32'h1)
                          * 32'(TO_STEP_CYC);
    assign to_set       = to_tmr.done && !pwm_mode_en;

    // next values; every set term wins over the read clear
    always_comb begin
        sc_st_d   = sc_st_q;
        txmask_d  = txmask_q;
        lvctrl_d  = lvctrl_q;
        conv_d    = conv_q;
        rdata_d   = rdata_q;
        co_arm_d  = co_arm_q;
        co_lock_d = co_lock_q;
        uv_lock_d = uv_lock_q;

        // short-circuit tracking
        case (sc_st_q)
            FMON_SC_IDLE:  if (boost_active) sc_st_d = FMON_SC_WATCH;
            FMON_SC_WATCH: begin
                if (!boost_active)
                    sc_st_d = FMON_SC_IDLE;
                else if (s_vout_ok && s_vled_ok)
                    sc_st_d = FMON_SC_GOOD;
                else if (sc_set)
                    sc_st_d = FMON_SC_SHORT;
            end
            FMON_SC_GOOD:  if (!boost_active) sc_st_d = FMON_SC_IDLE;
            FMON_SC_SHORT: begin
                if (s_vout_reg && s_vled_ok)
                    sc_st_d = FMON_SC_IDLE;
            end
            default:       sc_st_d = FMON_SC_IDLE;
        endcase

        // fault flags, cleared by a read of their register; over-temperature also needs cooling
        f_sc_d  = (sc_st_q == FMON_SC_WATCH && sc_set)
                  || (f_sc_q && !rd_fault);
        f_ot_d  = s_hot || (f_ot_q && !(rd_fault && s_cool));
        f_to_d  = to_set || (f_to_q && !rd_fault);
        f_uv_d  = s_uv || (f_uv_q && !rd_fault);
        f_co_d  = s_cap_open || (f_co_q && !rd_conv);
        f_ilv_d = (lvctrl_q[FMON_LOW_VOLTAGE_DETECT_ENABLE_BIT] && s_vin_low && !flash_active)
                  || (f_ilv_q && !rd_fault);
        f_txm_d = (txmask_q[FMON_TXM_EN_BIT] && s_txm_pin)
                  || (f_txm_q && !rd_fault);

        // lockout needs recovery and a cleared flag
        if (s_uv)
            uv_lock_d = 1'b1;
        else if (uv_lock_q && s_uv_rec && !f_uv_q)
            uv_lock_d = 1'b0;

        // capacitor lockout released by reset bit one then zero
        if (s_cap_open) begin
            co_lock_d = 1'b1;
            co_arm_d  = 1'b0;
        end else if (co_lock_q && wr_lv) begin
            if (state_machine_reset_bit_new)
                co_arm_d = 1'b1;
            else if (co_arm_q) begin
                co_lock_d = 1'b0;
                co_arm_d  = 1'b0;
            end
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                FMON_OFS_TXMASK: txmask_d = reg_wdata;
                FMON_OFS_LVCTRL: lvctrl_d = reg_wdata;
                FMON_OFS_CONV:   conv_d   = reg_wdata & FMON_CONV_RW_MASK;
                default:         ;
            endcase
        end

        // read data, unmapped offsets answer zero
        if (reg_rd) begin
            case (reg_addr)
                FMON_OFS_TXMASK: rdata_d = txmask_q;
                FMON_OFS_LVCTRL: rdata_d = lvctrl_q;
                FMON_OFS_FAULT: begin
                    rdata_d = 8'h00;
                    rdata_d[FMON_F_SC_BIT]  = f_sc_q;
                    rdata_d[FMON_F_OT_BIT]  = f_ot_q;
                    rdata_d[FMON_F_TO_BIT]  = f_to_q;
                    rdata_d[FMON_F_TXM_BIT] = f_txm_q;
                    rdata_d[FMON_F_ILV_BIT] = f_ilv_q;
                    rdata_d[FMON_F_UV_BIT]  = f_uv_q;
                end
                FMON_OFS_CONV: begin
                    rdata_d = conv_q;
                    rdata_d[FMON_C_CO_BIT] = f_co_q;
                end
                default:         rdata_d = 8'h00;
            endcase
        end

        // inductor limit only trims the charge phase, no flag
        cend_d = s_ilim && charge_phase;

        // report-only flags stay out of the standby term
        stby_d = f_sc_d || f_ot_d || f_to_d || f_uv_d || f_co_d
                 || uv_lock_d || co_lock_d
                 || (sc_st_d == FMON_SC_SHORT);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sc_st_q   <= FMON_SC_IDLE;
            txmask_q  <= FMON_TXMASK_RST;
            lvctrl_q  <= FMON_LVCTRL_RST;
            conv_q    <= FMON_CONV_RST;
            f_sc_q    <= 1'b0;
            f_ot_q    <= 1'b0;
            f_to_q    <= 1'b0;
            f_uv_q    <= 1'b0;
            f_co_q    <= 1'b0;
            f_ilv_q   <= 1'b0;
            f_txm_q   <= 1'b0;
            uv_lock_q <= 1'b0;
            co_lock_q <= 1'b0;
            co_arm_q  <= 1'b0;
            force_standby <= 1'b0;
            rdata_q   <= 8'h00;
            cend_q    <= 1'b0;
        end else begin
            sc_st_q   <= sc_st_d;
            txmask_q  <= txmask_d;
            lvctrl_q  <= lvctrl_d;
            conv_q    <= conv_d;
            f_sc_q    <= f_sc_d;
            f_ot_q    <= f_ot_d;
            f_to_q    <= f_to_d;
            f_uv_q    <= f_uv_d;
            f_co_q    <= f_co_d;
            f_ilv_q   <= f_ilv_d;
            f_txm_q   <= f_txm_d;
            uv_lock_q <= uv_lock_d;
            co_lock_q <= co_lock_d;
            co_arm_q  <= co_arm_d;
            force_standby <= stby_d;
            rdata_q   <= rdata_d;
            cend_q    <= cend_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // standby comes from a flop so no comb glitch reaches the power stage
    assign reg_rdata    = rdata_q;
    assign charge_end   = cend_q;
    assign ilim_sel     = {txmask_q[FMON_ILIM_HI_BIT],
                           txmask_q[FMON_ILIM_LO_BIT]};
    assign lv_threshold = lvctrl_q[FMON_LVL_LSB +: FMON_LVL_W];

endmodule // fmon_fault_monitor

// ==== src/fmon_pkg.sv ====
package fmon_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] FMON_OFS_TXMASK = 8'h03;
    localparam logic [7:0] FMON_OFS_LVCTRL = 8'h04;
    localparam logic [7:0] FMON_OFS_FAULT  = 8'h08;
    localparam logic [7:0] FMON_OFS_CONV   = 8'h09;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int FMON_TXM_EN_BIT  = 7;  // transmit_mask_enable
    localparam int FMON_ILIM_LO_BIT = 0;  // current_limit_sel_lo
    localparam int FMON_ILIM_HI_BIT = 1;  // current_limit_sel_hi
    localparam int FMON_STATE_MACHINE_RESET_BIT_BIT    = 7;  // state_machine_reset_bit
    localparam int FMON_LOW_VOLTAGE_DETECT_ENABLE_BIT    = 6;  // low_voltage_detect_enable
    localparam int FMON_LVL_LSB     = 0;  // low_voltage_threshold_field
    localparam int FMON_LVL_W       = 3;
    localparam int FMON_F_SC_BIT    = 6;
    localparam int FMON_F_OT_BIT    = 5;
    localparam int FMON_F_TO_BIT    = 4;
    localparam int FMON_F_TXM_BIT   = 3;
    localparam int FMON_F_ILV_BIT   = 1;
    localparam int FMON_F_UV_BIT    = 0;
    localparam int FMON_C_CO_BIT    = 4;
    localparam logic [7:0] FMON_CONV_RW_MASK = 8'hE0;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] FMON_TXMASK_RST = 8'h01; // limit code 01
    localparam logic [7:0] FMON_LVCTRL_RST = 8'h00;
    localparam logic [7:0] FMON_CONV_RST   = 8'h00;

    // current limit codes, ascending
    localparam logic [1:0] FMON_ILIM_2A3 = 2'h0;
    localparam logic [1:0] FMON_ILIM_2A6 = 2'h1;
    localparam logic [1:0] FMON_ILIM_2A9 = 2'h2;
    localparam logic [1:0] FMON_ILIM_3A3 = 2'h3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int FMON_CLK_MHZ     = 100;
    localparam int FMON_SC_WIN_US   = 500;  // 0.5 ms
    localparam int FMON_SC_WIN_CYC  = FMON_SC_WIN_US * FMON_CLK_MHZ;
    localparam int FMON_TO_STEP_MS  = 2;
    localparam int FMON_TO_STEP_CYC = FMON_TO_STEP_MS * 1000 * FMON_CLK_MHZ;

    typedef enum logic [1:0] {
        FMON_SC_IDLE,
        FMON_SC_WATCH,
        FMON_SC_GOOD,
        FMON_SC_SHORT
    } fmon_sc_e;

endpackage

// ==== src/fmon_timer.sv ====
module fmon_timer
    import fmon_pkg::*;
(
    input  wire logic     sys_clk,
    input  wire logic     resetn,
    fmon_tmr_if.timer     tmr
);
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        done_q;
    logic        done_d;

    // saturating count; a dropped run restarts the window
    always_comb begin
        cnt_d  = cnt_q;
        done_d = done_q;
        if (!tmr.run) begin
            cnt_d  = 32'h0;
            done_d = 1'b0;
        end else if (cnt_q >= tmr.limit - 32'h1) begin
            done_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cnt_q  <= 32'h0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign tmr.done = done_q;
endmodule // fmon_timer

// ==== src/fmon_tmr_if.sv ====
interface fmon_tmr_if;
    logic        run;    // count while high, restart when low
    logic [31:0] limit;  // cycles until expiry
    logic        done;   // level, high once limit reached

    modport owner (output run, output limit, input done);
    modport timer (input run, input limit, output done);
endinterface
